// ---- snf_consts.svh ----
`ifndef SNF_CONSTS_SVH
`define SNF_CONSTS_SVH
// Opcodes, shifted in most significant bit first
`define SNF_OP_STATUS_READ 8'h05
`define SNF_OP_STATUS_WRITE 8'h01
`define SNF_OP_MEM_WRITE 8'h02
`define SNF_OP_MEM_READ 8'h03
`define SNF_OP_FAST_READ 8'h0b
`define SNF_OP_SS_STORE 8'h42
`define SNF_OP_SS_FETCH 8'h4b
`define SNF_OP_DEV_IDENT 8'h9f
`define SNF_OP_UNIQ_IDENT 8'h4c
`define SNF_OP_SERIAL_STORE 8'hc2
`define SNF_OP_SERIAL_FETCH 8'hc3
`define SNF_OP_DEEP_SLEEP 8'hba
`define SNF_OP_HIBERNATE 8'hb9
// Framing counts
`define SNF_BIT_LAST 3'h7
`define SNF_BIT_FIRST 3'h0
`define SNF_ADDR_LAST 2'h2
`define SNF_ADDR_W 18
// Status register bit positions
`define SNF_SR_GUARD 7
`define SNF_SR_ONE 6
`define SNF_SR_LOCK_HI 3
`define SNF_SR_LOCK_LO 2
`define SNF_SR_WLATCH 1
`define SNF_SR_BUSY 0
// Reset and fixed values
`define SNF_GUARD_RST 1'h0
`define SNF_LOCK_RST 2'h0
// Block lock codes and range starts
`define SNF_LOCK_NONE 2'h0
`define SNF_LOCK_QUARTER 2'h1
`define SNF_LOCK_HALF 2'h2
`define SNF_LOCK_ALL 2'h3
`define SNF_QUARTER_BASE 18'h30000
`define SNF_HALF_BASE 18'h20000
// Receive buffer shape
`define SNF_FIFO_W 8
`define SNF_FIFO_DEPTH 32
`endif

// ---- snf_pkg.sv ----
package snf_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_opcode = 3'h1,
    st_addr = 3'h2,
    st_dummy = 3'h3,
    st_data = 3'h4,
    st_ignore = 3'h5
  } snf_state_type;

  typedef enum logic [3:0] {
    cmd_none = 4'h0,
    status_read_cmd = 4'h1,
    status_write_cmd = 4'h2,
    mem_write_cmd = 4'h3,
    mem_read_cmd = 4'h4,
    fast_read_cmd = 4'h5,
    special_sector_store_cmd = 4'h6,
    special_sector_fetch_cmd = 4'h7,
    device_ident_read_cmd = 4'h8,
    unique_ident_read_cmd = 4'h9,
    board_serial_store_cmd = 4'ha,
    board_serial_fetch_cmd = 4'hb,
    deep_sleep_cmd = 4'hc,
    hibernation_cmd = 4'hd
  } snf_cmd_type;
endpackage

// ---- snf_stream_if.sv ----
`timescale 1ns/10ps
`include "snf_consts.svh"
interface snf_stream_if;
  logic wr_valid;
  logic wr_ready;
  logic [`SNF_FIFO_W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [`SNF_FIFO_W-1:0] rd_data;
  modport buffer (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
  modport front (output wr_valid, output wr_data, output rd_ready,
                 input wr_ready, input rd_valid, input rd_data);
endinterface // snf_stream_if

// ---- snf_fifo.sv ----
`timescale 1ns/10ps
`include "snf_consts.svh"
module snf_fifo #(
  parameter int WIDTH = `SNF_FIFO_W,
  parameter int DEPTH = `SNF_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  snf_stream_if.buffer port_io
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign port_io.wr_ready = !full;
  assign port_io.rd_valid = !empty;
  assign port_io.rd_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = port_io.wr_valid && !full;
  assign do_rd = port_io.rd_ready && !empty;

  // Pointer advance
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_wr) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage carries no reset, contents gated by pointers
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= port_io.wr_data;
    end
  end
endmodule // snf_fifo

// ---- snf_front.sv ----
`timescale 1ns/10ps
`include "snf_consts.svh"
module snf_front (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic wake_busy_in,
  input wire logic [1:0] block_lock_nv_in,
  output logic [1:0] block_lock_out,
  output logic cmd_valid_out,
  output snf_pkg::snf_cmd_type cmd_out,
  output logic addr_valid_out,
  output logic [`SNF_ADDR_W-1:0] addr_out,
  output logic write_locked_out,
  output logic rd_req_out,
  input wire logic [7:0] rd_data_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  output logic rx_room_out,
  output logic frame_end_out
);
  // Pin synchronisers: stage one feeds stage two only
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic sck_d;
  logic cs_n_d;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic wp_n_s;
  logic rise_evt;
  logic fall_evt;
  logic sel_evt;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1 <= 4'h1;
      pin_s2 <= 4'h1;
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      pin_s1 <= {wp_n_in, si_in, sck_in, cs_n_in};
      pin_s2 <= pin_s1;
      sck_d <= pin_s2[1];
      cs_n_d <= pin_s2[0];
    end
  end

  assign cs_n_s = pin_s2[0];
  assign sck_s = pin_s2[1];
  assign si_s = pin_s2[2];
  assign wp_n_s = pin_s2[3];
  assign rise_evt = sck_s && !sck_d;
  assign fall_evt = !sck_s && sck_d;
  assign sel_evt = !cs_n_s && cs_n_d;

  // Opcode table; anything unlisted maps to none
  function automatic snf_pkg::snf_cmd_type decode(input logic [7:0] op);
    case (op)
      `SNF_OP_STATUS_READ: decode = snf_pkg::status_read_cmd;
      `SNF_OP_STATUS_WRITE: decode = snf_pkg::status_write_cmd;
      `SNF_OP_MEM_WRITE: decode = snf_pkg::mem_write_cmd;
      `SNF_OP_MEM_READ: decode = snf_pkg::mem_read_cmd;
      `SNF_OP_FAST_READ: decode = snf_pkg::fast_read_cmd;
      `SNF_OP_SS_STORE: decode = snf_pkg::special_sector_store_cmd;
      `SNF_OP_SS_FETCH: decode = snf_pkg::special_sector_fetch_cmd;
      `SNF_OP_DEV_IDENT: decode = snf_pkg::device_ident_read_cmd;
      `SNF_OP_UNIQ_IDENT: decode = snf_pkg::unique_ident_read_cmd;
      `SNF_OP_SERIAL_STORE: decode = snf_pkg::board_serial_store_cmd;
      `SNF_OP_SERIAL_FETCH: decode = snf_pkg::board_serial_fetch_cmd;
      `SNF_OP_DEEP_SLEEP: decode = snf_pkg::deep_sleep_cmd;
      `SNF_OP_HIBERNATE: decode = snf_pkg::hibernation_cmd;
      default: decode = snf_pkg::cmd_none;
    endcase
  endfunction

  function automatic logic needs_addr(input snf_pkg::snf_cmd_type c);
    needs_addr = (c == snf_pkg::mem_write_cmd) || (c == snf_pkg::mem_read_cmd) ||
                 (c == snf_pkg::fast_read_cmd) || (c == snf_pkg::special_sector_store_cmd) ||
                 (c == snf_pkg::special_sector_fetch_cmd);
  endfunction

  function automatic logic is_read(input snf_pkg::snf_cmd_type c);
    is_read = (c == snf_pkg::status_read_cmd) || (c == snf_pkg::mem_read_cmd) ||
              (c == snf_pkg::fast_read_cmd) || (c == snf_pkg::special_sector_fetch_cmd) ||
              (c == snf_pkg::device_ident_read_cmd) || (c == snf_pkg::unique_ident_read_cmd) ||
              (c == snf_pkg::board_serial_fetch_cmd);
  endfunction

  // Lock code against an 18-bit address
  function automatic logic locked(input logic [1:0] code, input logic [`SNF_ADDR_W-1:0] a);
    case (code)
      `SNF_LOCK_QUARTER: locked = (a >= `SNF_QUARTER_BASE);
      `SNF_LOCK_HALF: locked = (a >= `SNF_HALF_BASE);
      `SNF_LOCK_ALL: locked = 1'b1;
      default: locked = 1'b0;
    endcase
  endfunction

  // Front state
  snf_pkg::snf_state_type state;
  snf_pkg::snf_state_type next_state;
  snf_pkg::snf_cmd_type cmd;
  snf_pkg::snf_cmd_type next_cmd;
  logic mode3;
  logic next_mode3;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [1:0] byte_cnt;
  logic [1:0] next_byte_cnt;
  logic [7:0] rx_shift;
  logic [7:0] next_rx_shift;
  logic [23:0] addr_shift;
  logic [23:0] next_addr_shift;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic guard;
  logic next_guard;
  logic [1:0] lock;
  logic [1:0] next_lock;
  logic nv_loaded;
  logic next_nv_loaded;
  logic cmd_valid;
  logic next_cmd_valid;
  logic addr_valid;
  logic next_addr_valid;
  logic rd_req;
  logic next_rd_req;
  logic frame_end;
  logic next_frame_end;
  logic push;
  logic next_push;
  logic [7:0] push_byte;
  logic [7:0] next_push_byte;
  logic [7:0] status;
  logic [7:0] sh;
  logic sr_write_ok;
  snf_pkg::snf_cmd_type dec;

  // Status image with fixed bits; latch flag tied high
  always_comb begin
    status = 8'h00;
    status[`SNF_SR_GUARD] = guard;
    status[`SNF_SR_ONE] = 1'b1;
    status[`SNF_SR_LOCK_HI] = lock[1];
    status[`SNF_SR_LOCK_LO] = lock[0];
    status[`SNF_SR_WLATCH] = 1'b1;
    status[`SNF_SR_BUSY] = wake_busy_in;
  end

  // Guard pin only matters once guard enable is set
  assign sr_write_ok = !(guard && !wp_n_s);
  assign sh = {rx_shift[6:0], si_s};
  assign dec = decode(sh);

  // Framing, decode and status update
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_mode3 = mode3;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_rx_shift = rx_shift;
    next_addr_shift = addr_shift;
    next_tx_shift = tx_shift;
    next_guard = guard;
    next_lock = lock;
    next_nv_loaded = 1'b1;
    next_cmd_valid = 1'b0;
    next_addr_valid = 1'b0;
    next_rd_req = 1'b0;
    next_frame_end = 1'b0;
    next_push = 1'b0;
    next_push_byte = push_byte;
    // Lock pair restored from the nonvolatile cell after reset
    if (!nv_loaded) begin
      next_lock = block_lock_nv_in;
    end
    if (cs_n_s) begin
      // Deselect drops any partial byte and ends the frame
      if (state != snf_pkg::st_idle) begin
        next_frame_end = 1'b1;
      end
      next_state = snf_pkg::st_idle;
      next_bit_cnt = `SNF_BIT_FIRST;
    end else if (sel_evt) begin
      next_state = snf_pkg::st_opcode;
      next_mode3 = sck_s;
      next_cmd = snf_pkg::cmd_none;
      next_bit_cnt = `SNF_BIT_FIRST;
      next_byte_cnt = 2'h0;
    end else begin
      // Mode 3 starts high, so its first rising edge follows a toggle
      if (rise_evt && state != snf_pkg::st_idle && state != snf_pkg::st_ignore) begin
        next_rx_shift = sh;
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == `SNF_BIT_LAST) begin
          case (state)
            snf_pkg::st_opcode: begin
              next_cmd = dec;
              if (dec == snf_pkg::cmd_none) begin
                next_state = snf_pkg::st_ignore;
              end else begin
                next_cmd_valid = 1'b1;
                if (needs_addr(dec)) begin
                  next_state = snf_pkg::st_addr;
                end else if (dec == snf_pkg::deep_sleep_cmd ||
                             dec == snf_pkg::hibernation_cmd) begin
                  next_state = snf_pkg::st_ignore;
                end else begin
                  next_state = snf_pkg::st_data;
                  next_rd_req = is_read(dec) && (dec != snf_pkg::status_read_cmd);
                end
              end
            end
            snf_pkg::st_addr: begin
              next_addr_shift = {addr_shift[15:0], sh};
              next_byte_cnt = byte_cnt + 2'h1;
              if (byte_cnt == `SNF_ADDR_LAST) begin
                next_addr_valid = 1'b1;
                if (cmd == snf_pkg::fast_read_cmd) begin
                  next_state = snf_pkg::st_dummy;
                end else begin
                  next_state = snf_pkg::st_data;
                  next_rd_req = is_read(cmd);
                end
              end
            end
            snf_pkg::st_dummy: begin
              next_state = snf_pkg::st_data;
              next_rd_req = 1'b1;
            end
            snf_pkg::st_data: begin
              if (cmd == snf_pkg::status_write_cmd) begin
                if (sr_write_ok) begin
                  next_guard = sh[`SNF_SR_GUARD];
                  next_lock = {sh[`SNF_SR_LOCK_HI], sh[`SNF_SR_LOCK_LO]};
                end
              end else if (is_read(cmd)) begin
                next_rd_req = (cmd != snf_pkg::status_read_cmd);
              end else begin
                next_push = 1'b1;
                next_push_byte = sh;
              end
            end
            default: begin
              next_state = state;
            end
          endcase
        end
      end
      // Output bits change only after a falling edge
      if (fall_evt && state == snf_pkg::st_data && is_read(cmd)) begin
        if (bit_cnt == `SNF_BIT_FIRST) begin
          next_tx_shift = (cmd == snf_pkg::status_read_cmd) ? status : rd_data_in;
        end else begin
          next_tx_shift = {tx_shift[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= snf_pkg::st_idle;
      cmd <= snf_pkg::cmd_none;
      mode3 <= 1'b0;
      bit_cnt <= `SNF_BIT_FIRST;
      byte_cnt <= 2'h0;
      rx_shift <= 8'h00;
      addr_shift <= 24'h000000;
      tx_shift <= 8'h00;
      guard <= `SNF_GUARD_RST;
      lock <= `SNF_LOCK_RST;
      nv_loaded <= 1'b0;
      cmd_valid <= 1'b0;
      addr_valid <= 1'b0;
      rd_req <= 1'b0;
      frame_end <= 1'b0;
      push <= 1'b0;
      push_byte <= 8'h00;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      mode3 <= next_mode3;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      rx_shift <= next_rx_shift;
      addr_shift <= next_addr_shift;
      tx_shift <= next_tx_shift;
      guard <= next_guard;
      lock <= next_lock;
      nv_loaded <= next_nv_loaded;
      cmd_valid <= next_cmd_valid;
      addr_valid <= next_addr_valid;
      rd_req <= next_rd_req;
      frame_end <= next_frame_end;
      push <= next_push;
      push_byte <= next_push_byte;
    end
  end

  // Receive buffer; a byte arriving when full is lost, SPI cannot stall
  snf_stream_if rx_if ();
  assign rx_if.wr_valid = push;
  assign rx_if.wr_data = push_byte;
  assign rx_if.rd_ready = rx_ready_in;
  snf_fifo #(.WIDTH(`SNF_FIFO_W), .DEPTH(`SNF_FIFO_DEPTH)) u_rx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .port_io(rx_if)
  );

  // Outputs
  assign so_out = tx_shift[7];
  assign so_oe_out = !cs_n_s && state == snf_pkg::st_data && is_read(cmd);
  assign addr_out = addr_shift[`SNF_ADDR_W-1:0];
  assign write_locked_out = locked(lock, addr_out);
  assign block_lock_out = lock;
  assign cmd_valid_out = cmd_valid;
  assign cmd_out = cmd;
  assign addr_valid_out = addr_valid;
  assign rd_req_out = rd_req;
  assign frame_end_out = frame_end;
  assign rx_valid_out = rx_if.rd_valid;
  assign rx_data_out = rx_if.rd_data;
  assign rx_room_out = rx_if.wr_ready;

  // Checks
  property p_mode_pick;
    @(posedge clk_in) disable iff (rst_in) sel_evt && !cs_n_s |=> mode3 == $past(sck_s);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from clock");

  property p_quiet_off;
    @(posedge clk_in) disable iff (rst_in) cs_n_s |=> state == snf_pkg::st_idle && !so_oe_out;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("output driven while idle");

  property p_bad_op;
    @(posedge clk_in) disable iff (rst_in)
      state == snf_pkg::st_ignore && cmd == snf_pkg::cmd_none |->
      !so_oe_out && !cmd_valid_out && !next_push;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("activity after bad opcode");

  property p_fixed_bits;
    @(posedge clk_in) disable iff (rst_in)
      status[`SNF_SR_WLATCH] && status[`SNF_SR_ONE] && status[5:4] == 2'h0 &&
      (status[`SNF_SR_BUSY] == wake_busy_in);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

  property p_guard_block;
    @(posedge clk_in) disable iff (rst_in)
      guard && !wp_n_s && nv_loaded |=> $stable(lock) && guard;
  endproperty
  a_guard_block: assert property (p_guard_block) else $error("status written while guarded");

  property p_cmd_after_op;
    @(posedge clk_in) disable iff (rst_in)
      cmd_valid_out |-> $past(state) == snf_pkg::st_opcode && $past(bit_cnt) == `SNF_BIT_LAST;
  endproperty
  a_cmd_after_op: assert property (p_cmd_after_op) else $error("command not at eighth bit");

  property p_launch_fall;
    @(posedge clk_in) disable iff (rst_in)
      $changed(tx_shift) && state == snf_pkg::st_data |-> $past(fall_evt);
  endproperty
  a_launch_fall: assert property (p_launch_fall) else $error("output moved off falling edge");

  property p_lock_all;
    @(posedge clk_in) disable iff (rst_in)
      (lock == `SNF_LOCK_ALL |-> write_locked_out) and (lock == `SNF_LOCK_NONE |-> !write_locked_out);
  endproperty
  a_lock_all: assert property (p_lock_all) else $error("lock range wrong");

  property p_one_op;
    @(posedge clk_in) disable iff (rst_in) cmd_valid_out |=> !cmd_valid_out [*8];
  endproperty
  a_one_op: assert property (p_one_op) else $error("second opcode in frame");
endmodule // snf_front

// ---- snf_spi_master.sv ----
`timescale 1ns/10ps
module snf_spi_master (
  input wire logic clk_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  logic mode3 = 1'b0;
  logic oe_seen = 1'b0;
  // Idle bus: deselected, clock parked low
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // Half period of four clk cycles, moved off the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Clock parks at the mode level before select
  task automatic select(input logic m3);
    mode3 = m3;
    sck_out = m3;
    tick(4);
    cs_n_out = 1'b0;
    oe_seen = 1'b0;
    tick(4);
  endtask
  // Fall launches, rise captures; late sample tolerates output lag
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck_out = 1'b0;
      si_out = tx[i];
      tick(4);
      sck_out = 1'b1;
      tick(4);
      oe_seen = oe_seen | so_oe_in;
      rx[i] = so_oe_in ? so_in : ~so_in;
    end
  endtask
  // Every command ends here, so the next needs a fresh select
  task automatic deselect();
    tick(4);
    sck_out = mode3;
    tick(4);
    cs_n_out = 1'b1;
    si_out = ~si_out; // Released line shows no stale bit
    tick(8);
  endtask
endmodule // snf_spi_master

// ---- snf_testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sck, cs_n, si, so, so_oe, cmd_valid, addr_valid, write_locked, rd_req;
  logic wp_n = 1'b1;
  logic rx_ready = 1'b0;
  logic wake_busy = 1'b0;
  logic rx_valid, rx_room, frame_end;
  logic [1:0] lock_nv = 2'h2;
  logic [1:0] lock;
  snf_pkg::snf_cmd_type cmd;
  logic [17:0] addr;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] rx_data, got;
  logic [7:0] q[$];
  logic [7:0] ops[14] = '{8'h05, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h42, 8'h4b,
                          8'h9f, 8'h4c, 8'hc2, 8'hc3, 8'hba, 8'hb9, 8'h06};
  logic [23:0] adr[3] = '{24'hfdffff, 24'hfeffff, 24'hff0000};
  int miscompares = 0;
  int samples_checked = 0;
  int pulses = 0;
  int reqs = 0;
  int avs = 0;
  int ends = 0;
  int p;
  int e;
  // Clock
  always #12.5 clk_in = ~clk_in;
  // Count pulses away from the edge that launches them
  always @(negedge clk_in) begin
    if (cmd_valid === 1'b1) pulses++;
    if (rd_req === 1'b1) reqs++;
    if (addr_valid === 1'b1) avs++;
    if (frame_end === 1'b1) ends++;
  end
  snf_front dut (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .wp_n_in(wp_n), .so_out(so), .so_oe_out(so_oe),
    .wake_busy_in(wake_busy), .block_lock_nv_in(lock_nv), .block_lock_out(lock),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .addr_valid_out(addr_valid),
    .addr_out(addr), .write_locked_out(write_locked), .rd_req_out(rd_req),
    .rd_data_in(rd_data), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_ready_in(rx_ready), .rx_room_out(rx_room), .frame_end_out(frame_end));
  snf_spi_master master (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe),
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One selection; returns the last byte seen on the output line
  task automatic frame(input logic m3, input logic [7:0] b[$], output logic [7:0] r);
    master.select(m3);
    foreach (b[i]) master.shift(b[i], 8, r);
    master.deselect();
  endtask
  task automatic sr_write(input logic [7:0] v);
    frame(1'b0, '{8'h01, v}, got);
  endtask
  task automatic sr_check(input logic m3, input logic [7:0] exp);
    frame(m3, '{8'h05, 8'h00}, got);
    check("status", {24'h0, exp}, {24'h0, got});
  endtask
  // Check the buffer head, then pop it
  task automatic pop(input logic [7:0] exp);
    check("rx", {23'h0, 1'b1, exp}, {23'h0, rx_valid, rx_data});
    rx_ready = 1'b1;
    @(negedge clk_in);
    rx_ready = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected 0.3 milliseconds of traffic
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check("lock restore", 32'h2, {30'h0, lock});
    sr_check(1'b0, 8'h4a);
    sr_write(8'hff);
    sr_check(1'b1, 8'hce);
    wp_n = 1'b0;
    sr_write(8'h00);
    sr_check(1'b0, 8'hce);
    wp_n = 1'b1;
    sr_write(8'h00);
    sr_check(1'b1, 8'h42);
    // Wake-up busy level shows through bit 0
    wake_busy = 1'b1;
    sr_check(1'b0, 8'h43);
    wake_busy = 1'b0;
    // Every opcode once, alternating modes; last entry is reserved
    for (int i = 0; i < 14; i++) begin
      p = pulses;
      frame(i[0], '{ops[i], 8'h05, 8'h00}, got);
      check("pulses", (i < 13) ? 32'h1 : 32'h0, 32'(pulses - p));
      if (i < 13) check("cmd", 32'(i + 1), {28'h0, cmd});
      if (i == 13) check("oe", 32'h0, {31'h0, master.oe_seen});
    end
    // Serial store above left its two data bytes in the buffer
    pop(8'h05);
    pop(8'h00);
    check("drained", 32'h0, {31'h0, rx_valid});
    p = pulses;
    e = ends;
    master.select(1'b0);
    master.shift(8'h05, 5, got);
    master.deselect();
    check("partial", 32'h0, 32'(pulses - p));
    check("frame end", 32'h1, 32'(ends - e));
    // Lock codes against boundary addresses with junk leading bits
    for (int c = 0; c < 4; c++) begin
      sr_write({4'h0, c[1:0], 2'h0});
      for (int a = 0; a < 3; a++) begin
        p = avs;
        frame(1'b0, '{8'h02, adr[a][23:16], adr[a][15:8], adr[a][7:0]}, got);
        check("addr valid", 32'h1, 32'(avs - p));
        check("addr", {14'h0, adr[a][17:0]}, {14'h0, addr});
        check("locked", {31'h0, a >= 3 - c}, {31'h0, write_locked});
      end
    end
    sr_write(8'h00);
    rd_data = 8'ha5;
    // Reads send the ignored leading address bits as zeros
    p = reqs;
    frame(1'b0, '{8'h03, 8'h00, 8'h10, 8'h00, 8'h00}, got);
    check("read", 32'ha5, {24'h0, got});
    check("read reqs", 32'h2, 32'(reqs - p));
    p = reqs;
    frame(1'b1, '{8'h0b, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, got);
    check("fast read", 32'ha5, {24'h0, got});
    check("fast reqs", 32'h2, 32'(reqs - p));
    check("oe idle", 32'h0, {31'h0, so_oe});
    // Overfill the buffer while the user side stalls, then drain it
    q = '{8'h02, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 33; i++) q.push_back(8'(i));
    p = pulses;
    frame(1'b0, q, got);
    check("one opcode", 32'h1, 32'(pulses - p));
    check("room", 32'h0, {31'h0, rx_room});
    for (int i = 0; i < 32; i++) pop(8'(i));
    check("empty", 32'h0, {31'h0, rx_valid});
    stop_test();
  end
endmodule // testbench
